// File: shared/sfc_pkg.sv
// sfc_pkg: constants for the serial flash command and pause front end
// assumes: shared by the single design file, nothing imported
package sfc_pkg;

    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_WRITE_ARM    = 8'h06;
    localparam logic [7:0] OP_WRITE_DISARM = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ID_READ      = 8'h9F;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_DATA_READ    = 8'h03;
    localparam logic [7:0] OP_FAST_READ    = 8'h0B;
    localparam logic [7:0] OP_DUAL_READ    = 8'h3B;
    localparam logic [7:0] OP_PARAM_READ   = 8'h5A;
    localparam logic [7:0] OP_SIG_READ     = 8'hAB;
    localparam logic [7:0] OP_MAKER_DEV    = 8'h90;
    localparam logic [7:0] OP_WIPE_4K      = 8'h20;
    localparam logic [7:0] OP_BLOCK_WIPE_A = 8'h52;
    localparam logic [7:0] OP_BLOCK_WIPE_B = 8'hD8;
    localparam logic [7:0] OP_CHIP_WIPE_A  = 8'h60;
    localparam logic [7:0] OP_CHIP_WIPE_B  = 8'hC7;
    localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
    localparam logic [7:0] OP_LOCK_READ    = 8'h2B;
    localparam logic [7:0] OP_LOCK_WRITE   = 8'h2F;
    localparam logic [7:0] OP_OTP_ENTER    = 8'hB1;
    localparam logic [7:0] OP_OTP_LEAVE    = 8'hC1;
    localparam logic [7:0] OP_SLEEP_ENTER  = 8'hB9;

    // ----------------------------------------
    // frame layout, in bytes
    // ----------------------------------------
    localparam logic [2:0] HDR_NONE  = 3'h1;
    localparam logic [2:0] HDR_ADDR  = 3'h4;
    localparam logic [2:0] HDR_DUMMY = 3'h5;
    localparam logic [2:0] BYTES_SAT = 3'h7;
    localparam logic [2:0] LEN_WDATA = 3'h2;

    // ----------------------------------------
    // array operation codes towards the storage
    // ----------------------------------------
    localparam logic [2:0] AOP_STATUS = 3'h1;
    localparam logic [2:0] AOP_SECTOR = 3'h2;
    localparam logic [2:0] AOP_BLOCK  = 3'h3;
    localparam logic [2:0] AOP_CHIP   = 3'h4;
    localparam logic [2:0] AOP_PAGE   = 3'h5;

    // ----------------------------------------
    // status layout and reset values
    // ----------------------------------------
    localparam int         ST_SRWD    = 7;
    localparam int         ST_BP_HI   = 4;
    localparam int         ST_BP_LO   = 2;
    localparam logic [2:0] RST_BP     = 3'h0;
    localparam logic       RST_SRWD   = 1'b0;

    typedef enum logic [1:0] {
        SFC_IDLE = 2'b01,
        SFC_BUSY = 2'b10
    } sfc_state_t;

endpackage

// File: core/sfc_front.sv
// sfc_front: serial flash opcode interpreter with pause support
// assumes: sclk, cs_n, hold_n, sio0_in come from the host as one
// source-synchronous group; storage answers rd_data within half an sclk
//
// Behaviour
// - pause input low during a selected frame suspends all serial activity.
// - pause never stops a running status write, program or erase.
// - pause starts only with select low, at once, whatever the shift clock level.
// - pause ends on pause rising, whatever the shift clock level.
// - while paused, output floats; data input and shift clock ignored.
// - select rising while paused clears interface logic and ends the frame like any deselect; byte-aligned commands still execute.
// - 06 sets write latch, 04 clears it, 01 writes status; no address.
// - 9F returns maker byte then two device code bytes, no address.
// - 05 shifts out the status byte, no address.
// - 03 takes address, 0B address plus dummy; both stream until deselect.
// - 3B takes address plus dummy, then streams two bits per clock.
// - 5A takes address plus dummy, then returns parameter table data.
// - AB with three don't-care bytes returns one signature byte.
// - 90 with three address bytes returns maker and device codes, order selected by address bit 0.
// - 20 wipes sector, 52/D8 wipe block, 60/C7 wipe whole array.
// - 02 with address programs a page; 2B shifts out security byte.
// - 2F sets lock-down bit, which then stays set until reset.
// - B9 enters deep power-down, AB releases it.
// - input sampled on clock rise, output changed on clock fall.
// - write-type opcodes execute only if select rises on a byte boundary.
// - invalid opcode leaves output floating until the next frame.
`timescale 1ns/1ps
`default_nettype none

module sfc_front #(
    parameter logic [7:0]  MAKER_ID = 8'hA5,   // arbitrary value
    parameter logic [15:0] DEV_ID   = 16'h1234, // arbitrary value
    parameter logic [7:0]  SIG_ID   = 8'h3C    // arbitrary value
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        hold_n,
    input  wire logic        sio0_in,
    output logic             sio0_out,
    output logic             sio0_oe,
    output logic             sio1_out,
    output logic             sio1_oe,
    output logic [23:0]      rd_addr,
    output logic             rd_param,
    output logic             rd_otp,
    input  wire logic [7:0]  rd_data,
    output logic             array_op_go,
    output logic [2:0]       array_op_code,
    output logic [23:0]      array_op_addr,
    input  wire logic        array_op_done,
    output logic [7:0]       prog_byte,
    output logic             prog_byte_valid,
    output logic             deep_sleep,
    output logic             otp_mode,
    output logic             wip
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic [2:0] hdr_len(input logic [7:0] op);
        case (op)
            sfc_pkg::OP_DATA_READ, sfc_pkg::OP_WIPE_4K, sfc_pkg::OP_BLOCK_WIPE_A,
            sfc_pkg::OP_BLOCK_WIPE_B, sfc_pkg::OP_PAGE_WRITE, sfc_pkg::OP_MAKER_DEV,
            sfc_pkg::OP_SIG_READ:  hdr_len = sfc_pkg::HDR_ADDR;
            sfc_pkg::OP_FAST_READ, sfc_pkg::OP_DUAL_READ,
            sfc_pkg::OP_PARAM_READ: hdr_len = sfc_pkg::HDR_DUMMY;
            default:               hdr_len = sfc_pkg::HDR_NONE;
        endcase
    endfunction

    function automatic logic known(input logic [7:0] op, input logic asleep);
        case (op)
            sfc_pkg::OP_SIG_READ: known = 1'b1;
            sfc_pkg::OP_WRITE_ARM, sfc_pkg::OP_WRITE_DISARM, sfc_pkg::OP_STATUS_WRITE,
            sfc_pkg::OP_ID_READ, sfc_pkg::OP_STATUS_READ, sfc_pkg::OP_DATA_READ,
            sfc_pkg::OP_FAST_READ, sfc_pkg::OP_DUAL_READ, sfc_pkg::OP_PARAM_READ,
            sfc_pkg::OP_MAKER_DEV, sfc_pkg::OP_WIPE_4K, sfc_pkg::OP_BLOCK_WIPE_A,
            sfc_pkg::OP_BLOCK_WIPE_B, sfc_pkg::OP_CHIP_WIPE_A, sfc_pkg::OP_CHIP_WIPE_B,
            sfc_pkg::OP_PAGE_WRITE, sfc_pkg::OP_LOCK_READ, sfc_pkg::OP_LOCK_WRITE,
            sfc_pkg::OP_OTP_ENTER, sfc_pkg::OP_OTP_LEAVE,
            sfc_pkg::OP_SLEEP_ENTER: known = !asleep;
            default:               known = 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // link side, rising sclk: shift in
    // ----------------------------------------
    logic        in_frame, bad, frame_tog, prog_tog;
    logic [2:0]  bitpos, bytes;
    logic [6:0]  sh;
    logic [7:0]  opcode, prog_data;
    logic [23:0] addr;
    logic [1:0]  data_idx;
    logic        next_in_frame, next_bad, next_frame_tog, next_prog_tog, next_rd_param, next_rd_otp;
    logic [2:0]  next_bitpos, next_bytes, cur_bp, cur_by;
    logic [6:0]  next_sh;
    logic [7:0]  next_opcode, next_prog_data, byte_in;
    logic [23:0] next_addr;
    logic [1:0]  next_data_idx;
    logic        last, dual_in;
    logic [7:0]  stat_m, stat_s, sec_m, sec_s;
    logic        sleep_m, sleep_s, otp_m, otp_s;
    logic [7:0]  stat_byte, sec_byte;

    always_comb begin
        cur_bp         = in_frame ? bitpos : 3'h0;
        cur_by         = in_frame ? bytes : 3'h0;
        dual_in        = (opcode == sfc_pkg::OP_DUAL_READ) && (cur_by >= sfc_pkg::HDR_DUMMY);
        byte_in        = {sh, sio0_in};
        last           = dual_in ? (cur_bp == 3'h3) : (cur_bp == 3'h7);
        next_in_frame  = in_frame;
        next_bad       = bad;
        next_frame_tog = frame_tog;
        next_prog_tog  = prog_tog;
        next_bitpos    = bitpos;
        next_bytes     = bytes;
        next_sh        = sh;
        next_opcode    = opcode;
        next_prog_data = prog_data;
        next_addr      = addr;
        next_data_idx  = data_idx;
        next_rd_param  = rd_param;
        next_rd_otp    = rd_otp;
        if (hold_n) begin
            next_in_frame = 1'b1;
            if (!in_frame) begin
                next_frame_tog = ~frame_tog;
            end
            next_sh     = byte_in[6:0];
            next_bitpos = last ? 3'h0 : 3'(cur_bp + 3'h1);
            next_bytes  = cur_by;
            if (last) begin
                if (cur_by != sfc_pkg::BYTES_SAT) begin
                    next_bytes = 3'(cur_by + 3'h1);
                end
                if (cur_by == 3'h0) begin
                    next_opcode   = byte_in;
                    next_bad      = !known(byte_in, sleep_s);
                    next_data_idx = 2'h0;
                    next_rd_param = (byte_in == sfc_pkg::OP_PARAM_READ);
                    next_rd_otp   = otp_s;
                end else if (cur_by >= hdr_len(opcode)) begin
                    next_prog_data = byte_in;
                    next_data_idx  = (data_idx == ((opcode == sfc_pkg::OP_ID_READ) ? 2'h2 : 2'h1)) ?
                                     2'h0 : 2'(data_idx + 2'h1);
                    if (opcode == sfc_pkg::OP_PAGE_WRITE) begin
                        next_prog_tog = ~prog_tog;
                    end else if (opcode != sfc_pkg::OP_MAKER_DEV) begin
                        next_addr = 24'(addr + 24'h1);
                    end
                end else if (cur_by < sfc_pkg::HDR_ADDR) begin
                    next_addr = {addr[15:0], byte_in};
                end
            end
        end
    end

    always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
        if (cs_n || rst) begin
            in_frame <= 1'b0;
            bad      <= 1'b0;
        end else begin
            in_frame <= next_in_frame;
            bad      <= next_bad;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            frame_tog <= 1'b0;
            prog_tog  <= 1'b0;
        end else begin
            frame_tog <= next_frame_tog;
            prog_tog  <= next_prog_tog;
        end
    end

    always_ff @(posedge sclk) begin
        bitpos    <= next_bitpos;
        bytes     <= next_bytes;
        sh        <= next_sh;
        opcode    <= next_opcode;
        prog_data <= next_prog_data;
        addr      <= next_addr;
        data_idx  <= next_data_idx;
        rd_param  <= next_rd_param;
        rd_otp    <= next_rd_otp;
        stat_m    <= stat_byte;
        stat_s    <= stat_m;
        sec_m     <= sec_byte;
        sec_s     <= sec_m;
        sleep_m   <= deep_sleep;
        sleep_s   <= sleep_m;
        otp_m     <= otp_mode;
        otp_s     <= otp_m;
    end

    assign rd_addr = addr;

    // ----------------------------------------
    // link side, falling sclk: shift out
    // ----------------------------------------
    logic       out_kind, out_active, dual_out;
    logic [7:0] obuf, src, cur_out, next_obuf;
    logic       so1, so0, oe1, oe0, next_so1, next_so0, next_oe1, next_oe0;

    always_comb begin
        case (opcode)
            sfc_pkg::OP_ID_READ, sfc_pkg::OP_STATUS_READ, sfc_pkg::OP_LOCK_READ,
            sfc_pkg::OP_SIG_READ, sfc_pkg::OP_MAKER_DEV, sfc_pkg::OP_DATA_READ,
            sfc_pkg::OP_FAST_READ, sfc_pkg::OP_DUAL_READ, sfc_pkg::OP_PARAM_READ: out_kind = 1'b1;
            default: out_kind = 1'b0;
        endcase
        case (opcode)
            sfc_pkg::OP_ID_READ:     src = (data_idx == 2'h0) ? MAKER_ID :
                                           (data_idx == 2'h1) ? DEV_ID[15:8] : DEV_ID[7:0];
            sfc_pkg::OP_STATUS_READ: src = stat_s;
            sfc_pkg::OP_LOCK_READ:   src = sec_s;
            sfc_pkg::OP_SIG_READ:    src = SIG_ID;
            sfc_pkg::OP_MAKER_DEV:   src = (data_idx[0] ^ addr[0]) ? DEV_ID[7:0] : MAKER_ID;
            default:                 src = rd_data;
        endcase
        out_active = in_frame && !bad && (bytes != 3'h0) && out_kind && (bytes >= hdr_len(opcode));
        dual_out   = (opcode == sfc_pkg::OP_DUAL_READ);
        cur_out    = (bitpos == 3'h0) ? src : obuf;
        next_obuf  = obuf;
        next_so1   = so1;
        next_so0   = so0;
        next_oe1   = oe1;
        next_oe0   = oe0;
        if (hold_n) begin
            next_oe1 = out_active;
            next_oe0 = out_active && dual_out;
            if (out_active) begin
                next_obuf = cur_out;
                if (dual_out) begin
                    next_so1 = cur_out[~{bitpos[1:0], 1'b0}];
                    next_so0 = cur_out[~{bitpos[1:0], 1'b1}];
                end else begin
                    next_so1 = cur_out[~bitpos];
                end
            end
        end
    end

    always_ff @(negedge sclk or posedge cs_n or posedge rst) begin
        if (cs_n || rst) begin
            oe1 <= 1'b0;
            oe0 <= 1'b0;
        end else begin
            oe1 <= next_oe1;
            oe0 <= next_oe0;
        end
    end

    always_ff @(negedge sclk) begin
        obuf <= next_obuf;
        so1  <= next_so1;
        so0  <= next_so0;
    end

    assign sio1_out = so1;
    assign sio0_out = so0;
    assign sio1_oe  = oe1 && hold_n && !cs_n;
    assign sio0_oe  = oe0 && hold_n && !cs_n;

    // ----------------------------------------
    // system side: frame end and execution
    // ----------------------------------------
    sfc_pkg::sfc_state_t state, next_state;
    logic        cs_m, cs_s, cs_d, tog_m, tog_s, tog_seen, pg_m, pg_s, pg_d;
    logic        write_latch_flag, lock, srwd, fe, wr_ok, bound;
    logic [2:0]  bp;
    logic        next_wel, next_lock, next_srwd, next_sleep, next_otp, next_go, next_wip, next_seen;
    logic [2:0]  next_bp, next_code;
    logic [23:0] next_op_addr;

    assign stat_byte = {srwd, 2'b00, bp, write_latch_flag, wip};
    assign sec_byte  = {6'h00, lock, 1'b0};

    always_comb begin
        fe           = cs_s && !cs_d && (tog_s != tog_seen);
        bound        = (bitpos == 3'h0) && known(opcode, deep_sleep);
        wr_ok        = write_latch_flag && (state == sfc_pkg::SFC_IDLE) && bound;
        next_seen    = fe ? tog_s : tog_seen;
        next_state   = state;
        next_wel     = write_latch_flag;
        next_lock    = lock;
        next_srwd    = srwd;
        next_bp      = bp;
        next_sleep   = deep_sleep;
        next_otp     = otp_mode;
        next_go      = 1'b0;
        next_code    = array_op_code;
        next_op_addr = array_op_addr;
        if ((state == sfc_pkg::SFC_BUSY) && array_op_done) begin
            next_state = sfc_pkg::SFC_IDLE;
            next_wel   = 1'b0;
        end
        if (fe && bound) begin
            case (opcode)
                sfc_pkg::OP_WRITE_ARM:    if (bytes == 3'h1) next_wel = 1'b1;
                sfc_pkg::OP_WRITE_DISARM: if (bytes == 3'h1) next_wel = 1'b0;
                sfc_pkg::OP_STATUS_WRITE: if (wr_ok && bytes == sfc_pkg::LEN_WDATA) begin
                    next_srwd = prog_data[sfc_pkg::ST_SRWD];
                    next_bp   = prog_data[sfc_pkg::ST_BP_HI:sfc_pkg::ST_BP_LO];
                    next_code = sfc_pkg::AOP_STATUS;
                    next_go   = 1'b1;
                end
                sfc_pkg::OP_WIPE_4K: if (wr_ok && bytes == sfc_pkg::HDR_ADDR) begin
                    next_code = sfc_pkg::AOP_SECTOR;
                    next_go   = 1'b1;
                end
                sfc_pkg::OP_BLOCK_WIPE_A, sfc_pkg::OP_BLOCK_WIPE_B: if (wr_ok && bytes == sfc_pkg::HDR_ADDR) begin
                    next_code = sfc_pkg::AOP_BLOCK;
                    next_go   = 1'b1;
                end
                sfc_pkg::OP_CHIP_WIPE_A, sfc_pkg::OP_CHIP_WIPE_B: if (wr_ok && bytes == 3'h1) begin
                    next_code = sfc_pkg::AOP_CHIP;
                    next_go   = 1'b1;
                end
                sfc_pkg::OP_PAGE_WRITE: if (wr_ok && bytes > sfc_pkg::HDR_ADDR) begin
                    next_code = sfc_pkg::AOP_PAGE;
                    next_go   = 1'b1;
                end
                sfc_pkg::OP_LOCK_WRITE:   if (bytes == 3'h1) next_lock = 1'b1;
                sfc_pkg::OP_OTP_ENTER:    if (bytes == 3'h1) next_otp = 1'b1;
                sfc_pkg::OP_OTP_LEAVE:    if (bytes == 3'h1) next_otp = 1'b0;
                sfc_pkg::OP_SLEEP_ENTER:  if (bytes == 3'h1) next_sleep = 1'b1;
                sfc_pkg::OP_SIG_READ:     next_sleep = 1'b0;
                default: next_sleep = deep_sleep;
            endcase
        end
        if (next_go) begin
            next_state   = sfc_pkg::SFC_BUSY;
            next_op_addr = addr;
        end
        next_wip = (next_state == sfc_pkg::SFC_BUSY);
    end

    always_ff @(posedge clock) begin
        cs_m            <= cs_n;
        cs_s            <= cs_m;
        tog_m           <= frame_tog;
        tog_s           <= tog_m;
        pg_m            <= prog_tog;
        pg_s            <= pg_m;
        pg_d            <= pg_s;
        prog_byte_valid <= (pg_s != pg_d);
        prog_byte       <= prog_data;
        if (rst) begin
            cs_d          <= 1'b1;
            tog_seen      <= 1'b0;
            state         <= sfc_pkg::SFC_IDLE;
            write_latch_flag           <= 1'b0;
            lock          <= 1'b0;
            srwd          <= sfc_pkg::RST_SRWD;
            bp            <= sfc_pkg::RST_BP;
            deep_sleep    <= 1'b0;
            otp_mode      <= 1'b0;
            array_op_go   <= 1'b0;
            array_op_code <= 3'h0;
            array_op_addr <= 24'h000000;
            wip           <= 1'b0;
        end else begin
            cs_d          <= cs_s;
            tog_seen      <= next_seen;
            state         <= next_state;
            write_latch_flag           <= next_wel;
            lock          <= next_lock;
            srwd          <= next_srwd;
            bp            <= next_bp;
            deep_sleep    <= next_sleep;
            otp_mode      <= next_otp;
            array_op_go   <= next_go;
            array_op_code <= next_code;
            array_op_addr <= next_op_addr;
            wip           <= next_wip;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    go_sets_busy_a: assert property (@(posedge clock) disable iff (rst)
        array_op_go |-> wip && !$past(wip)) else $error("go without busy start");
    busy_holds_a: assert property (@(posedge clock) disable iff (rst)
        wip && !array_op_done |=> wip) else $error("busy dropped early");
    done_clears_latch_a: assert property (@(posedge clock) disable iff (rst)
        wip && array_op_done |=> !write_latch_flag && !wip) else $error("latch kept after done");
    lock_sticky_a: assert property (@(posedge clock) disable iff (rst)
        lock |=> lock [*8]) else $error("lock bit cleared");
    sleep_enter_a: assert property (@(posedge clock) disable iff (rst)
        fe && bound && opcode == sfc_pkg::OP_SLEEP_ENTER && bytes == 3'h1 |=> deep_sleep)
        else $error("sleep not entered");
    arm_sets_latch_a: assert property (@(posedge clock) disable iff (rst)
        fe && bound && opcode == sfc_pkg::OP_WRITE_ARM && bytes == 3'h1 && !wip |=> write_latch_flag)
        else $error("latch not set");
    odd_edge_reject_a: assert property (@(posedge clock) disable iff (rst)
        fe && bitpos != 3'h0 |=> !array_op_go) else $error("off-boundary executed");
    bad_floats_a: assert property (@(negedge sclk) disable iff (cs_n)
        bad |=> !oe1 && !oe0) else $error("driven after invalid opcode");
    read_addr_step_a: assert property (@(posedge sclk) disable iff (cs_n)
        in_frame && hold_n && opcode == sfc_pkg::OP_DATA_READ && bytes >= sfc_pkg::HDR_ADDR && bitpos == 3'h7
        |=> addr == 24'($past(addr) + 24'h1)) else $error("read address not stepped");
    pause_freeze_a: assert property (@(posedge sclk) disable iff (cs_n)
        in_frame && !hold_n |=> $stable(bitpos) && $stable(bytes)) else $error("shift during pause");

    erase_go_c: cover property (@(posedge clock) disable iff (rst)
        array_op_go && array_op_code == sfc_pkg::AOP_SECTOR);
    dual_out_c: cover property (@(negedge sclk) disable iff (cs_n) oe0);
    pause_mid_c: cover property (@(posedge sclk) disable iff (cs_n) in_frame && !hold_n ##1 hold_n);

endmodule

`default_nettype wire

// File: tb/sfc_host.sv
// sfc_host: spi host model, mode 0, drives the flash link
// assumes: sclk runs only inside frames, idles low
`timescale 1ns/1ps
`default_nettype none
module sfc_host (
    output var logic sclk,
    output var logic cs_n,
    output var logic hold_n,
    output var logic sio0_in,
    input  wire logic sio1_out
);
    // ------------------------------
    // frame tasks
    // ------------------------------
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        hold_n = 1'b1;
        sio0_in = 1'b0;
    end
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            sio0_in = d[i];
            #24 sclk = 1'b1;
            q[i] = sio1_out;
            #24 sclk = 1'b0;
        end
    endtask
    task automatic start();
        cs_n = 1'b0;
        #30;
    endtask
    task automatic stop();
        #30 cs_n = 1'b1;
        sio0_in = ~sio0_in;
        #150;
    endtask
    task automatic pause(input int n, input logic drop);
        #12 hold_n = 1'b0;
        repeat (n) begin
            sio0_in = ~sio0_in;
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        if (drop) cs_n = 1'b1;
        #30 hold_n = 1'b1;
        #30;
    endtask
endmodule
`default_nettype wire

// File: tb/serial_flash_cmd_hold_tb.sv
// serial_flash_cmd_hold_tb: self-checking bench of the flash front end
// assumes: sfc_host drives the link; storage modelled here
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("mismatch %0t: %h %h", $time, a, b); end end
module serial_flash_cmd_hold_tb;
    localparam logic [7:0]  M_ID = 8'h3E;   // arbitrary value
    localparam logic [15:0] D_ID = 16'h7142; // arbitrary value
    localparam logic [7:0]  S_ID = 8'h19;   // arbitrary value
    logic clock = 1'b0;
    logic rst = 1'b0;
    logic done = 1'b0;
    logic [2:0] goc = 3'h0;
    logic [23:0] goa, a;
    logic [7:0] q;
    int num_errors = 0;
    int compares = 0;
    int seed = 32'hb8562d81;
    wire logic sclk, cs_n, hold_n, sio0_in, s0o, s0e, s1o, s1e, go, rp, ro, ds, otp, wip, pv;
    wire logic [23:0] ra, oa;
    wire logic [2:0] oc;
    wire logic [7:0] pb;
    // ------------------------------
    // models and checks
    // ------------------------------
    function automatic logic [7:0] mem(input logic [23:0] x);
        return x[7:0] ^ x[23:16] ^ 8'h5C;
    endfunction
    always #12.5 clock = ~clock;
    always @(negedge clock) done <= go;
    always @(negedge clock) if (go === 1'b1) {goc, goa} <= {oc, oa};
    always @(negedge clock) if (hold_n === 1'b0) `CHK(s1e, 1'b0)
    sfc_front #(.MAKER_ID(M_ID), .DEV_ID(D_ID), .SIG_ID(S_ID)) uut (
        .clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .hold_n(hold_n), .sio0_in(sio0_in),
        .sio0_out(s0o), .sio0_oe(s0e), .sio1_out(s1o), .sio1_oe(s1e), .rd_addr(ra), .rd_param(rp),
        .rd_otp(ro), .rd_data(mem(ra)), .array_op_go(go), .array_op_code(oc), .array_op_addr(oa),
        .array_op_done(done), .prog_byte(pb), .prog_byte_valid(pv), .deep_sleep(ds), .otp_mode(otp), .wip(wip));
    sfc_host host (.sclk(sclk), .cs_n(cs_n), .hold_n(hold_n), .sio0_in(sio0_in), .sio1_out(s1o));
    task automatic tx(input logic [7:0] d);
        host.xfer(d, q);
    endtask
    task automatic rb(input logic [7:0] want);
        host.xfer(8'h00, q);
        `CHK(q, want)
    endtask
    task automatic hdr(input logic [7:0] op, input logic [31:0] x, input int n, input int h);
        host.start();
        tx(op);
        for (int i = 0; i < n; i++) begin
            if (i == h) host.pause(3, 1'b0);
            tx(x[31 - 8 * i -: 8]);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    initial begin
        #1 rst = 1'b1;
        repeat (10) @(negedge clock);
        rst = 1'b0;
        repeat (2) @(negedge clock);
        hdr(8'h9F, 32'h0, 0, 9);
        rb(M_ID);
        rb(D_ID[15:8]);
        rb(D_ID[7:0]);
        host.stop();
        for (int k = 0; k < 2; k++) begin
            hdr(8'h90, {16'h0000, k[7:0], 8'h00}, 3, 9);
            rb(k == 0 ? M_ID : D_ID[7:0]);
            rb(k == 0 ? D_ID[7:0] : M_ID);
            host.stop();
        end
        for (int k = 0; k < 4; k++) begin
            a = 24'($random(seed));
            hdr(k[0] ? 8'h0B : 8'h03, {a, 8'hFF}, 3 + k[0], k);
            rb(mem(a));
            host.pause(2, 1'b0);
            rb(mem(a + 24'h1));
            host.stop();
        end
        hdr(8'h03, 32'h0, 2, 9);
        host.pause(2, 1'b1);
        repeat (8) @(negedge clock);
        hdr(8'h9F, 32'h0, 0, 9);
        rb(M_ID);
        host.stop();
        hdr(8'h06, 32'h0, 0, 9);
        host.stop();
        hdr(8'h05, 32'h0, 0, 9);
        host.xfer(8'h00, q);
        `CHK(q[1], 1'b1)
        host.stop();
        a = 24'($random(seed));
        hdr(8'h20, {a, 8'h00}, 3, 9);
        host.stop();
        `CHK(goc, 3'h2)
        `CHK(goa, a)
        `CHK(wip, 1'b0)
        hdr(8'h06, 32'h0, 0, 9);
        host.stop();
        hdr(8'h04, 32'h0, 0, 9);
        host.stop();
        hdr(8'h05, 32'h0, 0, 9);
        host.xfer(8'h00, q);
        `CHK(q[1], 1'b0)
        host.stop();
        hdr(8'h2F, 32'h0, 0, 9);
        host.stop();
        hdr(8'h2B, 32'h0, 0, 9);
        rb(8'h02);
        host.stop();
        hdr(8'hB1, 32'h0, 0, 9);
        host.stop();
        `CHK(otp, 1'b1)
        hdr(8'hC1, 32'h0, 0, 9);
        host.stop();
        `CHK(otp, 1'b0)
        a = 24'($random(seed));
        hdr(8'h5A, {a, 8'hFF}, 4, 9);
        `CHK(rp, 1'b1)
        host.stop();
        hdr(8'h3B, {a, 8'hFF}, 4, 9);
        #10 q = mem(a);
        `CHK({s0e, s1o, s0o}, {1'b1, q[7:6]})
        host.stop();
        hdr(8'hB9, 32'h0, 0, 9);
        host.stop();
        `CHK(ds, 1'b1)
        hdr(8'h9F, 32'h0, 0, 9);
        host.xfer(8'h00, q);
        #10 `CHK(s1e, 1'b0)
        host.stop();
        hdr(8'hAB, 32'h0, 3, 9);
        rb(S_ID);
        host.stop();
        `CHK(ds, 1'b0)
        tally_and_finish();
    end
    initial begin
        #400000;
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
